/* dv/core_model.sv */
// Stand-in for the processor core: control writes and their retirement.
// Assumes the bench calls its task from one process.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic      clock,
  output var logic       pwr_wr,
  output var logic [7:0] pwr_wdata,
  output var logic       osc_wr,
  output var logic [7:0] osc_wdata,
  output var logic       instr_retire
);
  initial begin
    pwr_wr = 1'b0;
    osc_wr = 1'b0;
    pwr_wdata = 8'h00;
    osc_wdata = 8'h00;
    instr_retire = 1'b0;
  end
  // Data lines are inverted after a write so a stale byte never looks valid.
  task automatic wr(input logic to_osc, input logic [7:0] d);
    @(posedge clock);
    pwr_wr <= !to_osc;
    osc_wr <= to_osc;
    pwr_wdata <= d;
    osc_wdata <= d;
    @(posedge clock);
    pwr_wr <= 1'b0;
    osc_wr <= 1'b0;
    pwr_wdata <= ~d;
    osc_wdata <= ~d;
    instr_retire <= 1'b1;
    @(posedge clock);
    instr_retire <= 1'b0;
  endtask
endmodule // core_model
`default_nettype wire

/* dv/pmc_sva.sv */
// Port checker for the power mode controller.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pmc_sva #(parameter int ANALOG_N = 4) (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                instr_retire,
  input wire logic                irq_enabled_pending,
  input wire logic                watchdog_enable,
  input wire logic                watchdog_expire,
  input wire logic [ANALOG_N-1:0] analog_disable,
  input wire logic [7:0]          power_control_rd,
  input wire logic                cpu_clk_en,
  input wire logic                periph_clk_en,
  input wire logic                timers_run,
  input wire logic                int_reset_req,
  input wire logic [15:0]         fetch_vector,
  input wire logic                vector_load,
  input wire logic                resume_pulse,
  input wire logic [ANALOG_N-1:0] analog_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Checks
  property p_halt; $fell(cpu_clk_en) |-> $past(instr_retire); endproperty
  a_halt: assert property (p_halt) else $error("cpu clock fell without retire");
  property p_rd0; power_control_rd[1:0] == 2'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("mode bits read nonzero");
  property p_same; periph_clk_en == timers_run; endproperty
  a_same: assert property (p_same) else $error("peripheral and timer enables differ");
  property p_wake; !cpu_clk_en && periph_clk_en && irq_enabled_pending |=> cpu_clk_en; endproperty
  a_wake: assert property (p_wake) else $error("idle not left on interrupt");
  property p_resume; resume_pulse |-> $rose(cpu_clk_en) ##1 !resume_pulse; endproperty
  a_resume: assert property (p_resume) else $error("resume pulse misplaced");
  property p_vec; fetch_vector == 16'h0000; endproperty
  a_vec: assert property (p_vec) else $error("fetch vector not zero");
  property p_wdt; watchdog_enable && watchdog_expire |=> int_reset_req && vector_load; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog expiry gave no reset");
  property p_ana; 1'b1 |=> analog_enable == ~$past(analog_disable); endproperty
  a_ana: assert property (p_ana) else $error("analog enable wrong");
endmodule // pmc_sva
bind power_mode_controller pmc_sva #(.ANALOG_N(ANALOG_N)) u_pmc_sva (.clock(clock), .rst_n(rst_n),
  .instr_retire(instr_retire), .irq_enabled_pending(irq_enabled_pending), .watchdog_enable(watchdog_enable),
  .watchdog_expire(watchdog_expire), .analog_disable(analog_disable), .power_control_rd(power_control_rd),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .timers_run(timers_run),
  .int_reset_req(int_reset_req), .fetch_vector(fetch_vector), .vector_load(vector_load),
  .resume_pulse(resume_pulse), .analog_enable(analog_enable));
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the power mode controller.
// Assumes the core stand-in and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, rst_n, ext_reset, irq_enabled_pending, watchdog_enable, watchdog_expire;
  logic port_match, comparator_low, timer3_overflow, pwr_wr, osc_wr, instr_retire;
  logic missing_clk_enable, missing_clk_fault;
  logic cpu_clk_en, periph_clk_en, int_osc_run, timers_run, int_reset_req, vector_load, resume_pulse;
  logic [3:0] analog_disable, analog_enable;
  logic [7:0] pwr_wdata, osc_wdata, power_control_rd, oscillator_control_rd;
  logic [15:0] fetch_vector;
  int miscompares, samples_checked;
  core_model u_core_model (.clock, .pwr_wr, .pwr_wdata, .osc_wr, .osc_wdata, .instr_retire);
  power_mode_controller u_power_mode_controller (.clock, .rst_n, .ext_reset, .pwr_wr, .pwr_wdata,
    .osc_wr, .osc_wdata, .instr_retire, .irq_enabled_pending, .watchdog_enable, .watchdog_expire,
    .missing_clk_enable, .missing_clk_fault, .port_match, .comparator_low,
    .timer3_overflow, .analog_disable, .power_control_rd, .oscillator_control_rd, .cpu_clk_en,
    .periph_clk_en, .int_osc_run, .timers_run, .int_reset_req, .fetch_vector, .vector_load,
    .resume_pulse, .analog_enable);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_run();
    for (int i = 0; i < 20 && cpu_clk_en !== 1'b1; i++) tick(1);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_idle();
    u_core_model.wr(1'b0, 8'hA5);
    tick(1);
    chk(cpu_clk_en, 0);
    chk(periph_clk_en, 1);
    chk(power_control_rd, 8'hA4);
    @(posedge clock);
    irq_enabled_pending <= 1'b1;
    tick(1);
    chk(resume_pulse, 1);
    chk(power_control_rd, 8'hA4);
    @(posedge clock);
    irq_enabled_pending <= 1'b0;
  endtask
  task automatic t_wdt();
    u_core_model.wr(1'b0, 8'h01);
    @(posedge clock);
    watchdog_expire <= 1'b1;
    tick(2);
    chk(cpu_clk_en, 0);
    @(posedge clock);
    watchdog_enable <= 1'b1;
    tick(1);
    chk(int_reset_req, 1);
    chk(vector_load, 1);
    @(posedge clock);
    watchdog_expire <= 1'b0;
    watchdog_enable <= 1'b0;
    wait_run();
    chk(cpu_clk_en, 1);
  endtask
  task automatic t_stop();
    u_core_model.wr(1'b0, 8'h02);
    tick(1);
    chk({cpu_clk_en, int_osc_run, timers_run}, 0);
    @(posedge clock);
    irq_enabled_pending <= 1'b1;
    tick(4);
    chk(cpu_clk_en, 0);
    @(posedge clock);
    irq_enabled_pending <= 1'b0;
    ext_reset <= 1'b1;
    for (int i = 0; i < 10 && vector_load !== 1'b1; i++) tick(1);
    chk({vector_load, fetch_vector}, 17'h10000);
    @(posedge clock);
    ext_reset <= 1'b0;
    // The synchronised reset level lags the pin by several cycles.
    tick(6);
    chk(int_osc_run, 1);
  endtask
  task automatic t_mcd();
    u_core_model.wr(1'b0, 8'h02);
    @(posedge clock);
    missing_clk_fault <= 1'b1;
    tick(3);
    chk(cpu_clk_en, 0);
    @(posedge clock);
    missing_clk_enable <= 1'b1;
    tick(1);
    chk({int_reset_req, vector_load, cpu_clk_en}, 3'h7);
    @(posedge clock);
    {missing_clk_enable, missing_clk_fault} <= 2'h0;
    tick(2);
    chk(int_osc_run, 1);
  endtask
  task automatic t_susp();
    for (int k = 0; k < 3; k++) begin
      u_core_model.wr(1'b1, 8'h20);
      tick(1);
      chk({cpu_clk_en, int_osc_run}, 0);
      chk(oscillator_control_rd, 8'h20);
      @(posedge clock);
      port_match <= (k == 0);
      comparator_low <= (k == 1);
      timer3_overflow <= (k == 2);
      wait_run();
      chk(resume_pulse, 1);
      chk(oscillator_control_rd, 8'h00);
      @(posedge clock);
      {port_match, comparator_low, timer3_overflow} <= 3'h0;
      // Let the wake levels drain through the synchronisers before reuse.
      tick(6);
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #50000;
    miscompares++;
    finish_test();
  end
  initial begin
    {rst_n, ext_reset, irq_enabled_pending, watchdog_enable, watchdog_expire} = 5'h00;
    {port_match, comparator_low, timer3_overflow} = 3'h0;
    {missing_clk_enable, missing_clk_fault} = 2'h0;
    analog_disable = 4'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    analog_disable <= 4'h5;
    tick(2);
    chk({power_control_rd, cpu_clk_en}, 9'h001);
    chk(analog_enable, 4'hA);
    t_idle();
    t_wdt();
    t_stop();
    t_mcd();
    t_susp();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire

/* hdl/pmc_pkg.sv */
// Package of constants and types for the power mode controller.
// Assumes a single system clock domain; the core writes byte-wide control registers.
package pmc_pkg;

  // ==========================================================================
  // Register field positions
  localparam int PWR_IDLE_BIT    = 0;
  localparam int PWR_STOP_BIT    = 1;
  localparam int OSC_SUSPEND_BIT = 5;
  localparam int REG_W           = 8;

  // ==========================================================================
  // Reset values and vectors
  localparam logic [7:0]  GP_FLAGS_RST  = 8'h00;
  localparam logic [15:0] RESET_VECTOR  = 16'h0000;

  // ==========================================================================
  // Timing
  localparam int CLOCK_MHZ        = 100;
  localparam int RESET_HOLD_NS    = 100;
  localparam int RESET_HOLD_CYC   = (RESET_HOLD_NS * CLOCK_MHZ + 999) / 1000;

  // ==========================================================================
  // Power states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_IDLE_PEND,
    ST_STOP_PEND,
    ST_SUSP_PEND,
    ST_IDLE,
    ST_STOP,
    ST_SUSPEND
  } pwr_state_t;

endpackage : pmc_pkg

/* hdl/power_mode_controller.sv */
// Power mode controller: idle, stop and suspend entry and exit for a small core.
// Assumes the core writes control bytes on one clock, reports instruction
// retirement, and honours cpu_clk_en, osc_run and a reset request.
// How it works
// - Three low-power states selected by software
// - Idle bit halts CPU after instruction
// - Idle keeps registers and memory intact
// - Peripheral clocks keep running during idle
// - Enabled interrupt or reset ends idle
// - Interrupt wake clears idle, CPU resumes
// - After return, continue after idle instruction
// - Reset exit restarts fetch at zero
// - Watchdog expiry in idle forces reset
// - Stop halts CPU and internal oscillator
// - Suspend wakes on match, comparator, timer
// - Analog peripherals disable individually
// - Stop bit enters stop; only reset exits
// - Idle and stop bits read zero
// - Suspend wake resumes after setting instruction
`timescale 1ns/1ps
`default_nettype none

module power_mode_controller #(
  parameter int ANALOG_N = 4
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       ext_reset,
  input  wire logic                       pwr_wr,
  input  wire logic [pmc_pkg::REG_W-1:0]  pwr_wdata,
  input  wire logic                       osc_wr,
  input  wire logic [pmc_pkg::REG_W-1:0]  osc_wdata,
  input  wire logic                       instr_retire,
  input  wire logic                       irq_enabled_pending,
  input  wire logic                       watchdog_enable,
  input  wire logic                       watchdog_expire,
  input  wire logic                       missing_clk_enable,
  input  wire logic                       missing_clk_fault,
  input  wire logic                       port_match,
  input  wire logic                       comparator_low,
  input  wire logic                       timer3_overflow,
  input  wire logic [ANALOG_N-1:0]        analog_disable,
  output logic [pmc_pkg::REG_W-1:0]       power_control_rd,
  output logic [pmc_pkg::REG_W-1:0]       oscillator_control_rd,
  output logic                            cpu_clk_en,
  output logic                            periph_clk_en,
  output logic                            int_osc_run,
  output logic                            timers_run,
  output logic                            int_reset_req,
  output logic [15:0]                     fetch_vector,
  output logic                            vector_load,
  output logic                            resume_pulse,
  output logic [ANALOG_N-1:0]             analog_enable
);
  import pmc_pkg::*;

  // ==========================================================================
  // Limitations
  // The watchdog and missing clock detector inputs are taken as synchronous
  // to clock. An expiry that arrives while its source is disabled is dropped,
  // not remembered, so software can leave the core in idle for good.
  // The core must honour cpu_clk_en from the cycle after retirement; this
  // block only gates clocks and never touches the core's own storage.

  // ==========================================================================
  // State and register storage
  pwr_state_t          state_ff;
  pwr_state_t          nxt_state;
  logic [REG_W-1:0]    gp_flags_ff;
  logic [REG_W-1:0]    osc_ctrl_ff;
  logic                cpu_clk_en_ff;
  logic                periph_clk_en_ff;
  logic                int_osc_run_ff;
  logic                timers_run_ff;
  logic                int_reset_req_ff;
  logic                vector_load_ff;
  logic                resume_pulse_ff;
  logic [ANALOG_N-1:0] analog_enable_ff;
  logic [2:0]          ext_sync_ff;
  logic [2:0]          port_sync_ff;
  logic [2:0]          cmp_sync_ff;
  logic [2:0]          t3_sync_ff;
  logic                ext_level_ff;
  logic                port_level_ff;
  logic                cmp_level_ff;
  logic                t3_level_ff;
  logic                t3_prev_ff;

  // ==========================================================================
  // Pin synchronisers: a level changes once stages two and three agree.
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  wire ext_level_nxt  = filt(ext_sync_ff, ext_level_ff);
  wire port_level_nxt = filt(port_sync_ff, port_level_ff);
  wire cmp_level_nxt  = filt(cmp_sync_ff, cmp_level_ff);
  wire t3_level_nxt   = filt(t3_sync_ff, t3_level_ff);

  // ==========================================================================
  // Request decode
  wire idle_req    = pwr_wr && pwr_wdata[PWR_IDLE_BIT];
  wire stop_req    = pwr_wr && pwr_wdata[PWR_STOP_BIT];
  wire susp_req    = osc_wr && osc_wdata[OSC_SUSPEND_BIT];
  // Port match and comparator wakes are levels: a source that is still
  // active when suspend is entered wakes the core at once. A timer overflow
  // is taken on its rising edge, so one that came before entry is no wake.
  wire t3_edge     = t3_level_ff && !t3_prev_ff;
  wire susp_wake   = port_level_ff || cmp_level_ff || t3_edge;
  wire wd_reset    = watchdog_enable && watchdog_expire;
  wire mcd_reset   = missing_clk_enable && missing_clk_fault;
  wire any_reset   = ext_level_ff || wd_reset || mcd_reset;

  // ==========================================================================
  // Next-state logic
  // Run is the only state that accepts a mode write. A write moves to one of
  // the pending states, which wait for the core to retire the writing
  // instruction; only then is the halted state entered, so the setting
  // instruction always completes. Stop is left only by a reset; idle leaves
  // on an enabled interrupt and suspend on a wake source.
  // Writes that arrive while pending or halted still update the stored
  // flags but are not taken as new mode requests.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        // The write registers as a request; entry waits for retirement.
        if (stop_req) begin
          nxt_state = ST_STOP_PEND;
        end else if (susp_req) begin
          nxt_state = ST_SUSP_PEND;
        end else if (idle_req) begin
          nxt_state = ST_IDLE_PEND;
        end
      end
      ST_IDLE_PEND: begin
        if (instr_retire) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_STOP_PEND: begin
        if (instr_retire) begin
          nxt_state = ST_STOP;
        end
      end
      ST_SUSP_PEND: begin
        if (instr_retire) begin
          nxt_state = ST_SUSPEND;
        end
      end
      ST_IDLE: begin
        if (irq_enabled_pending) begin
          nxt_state = ST_RUN;
        end
      end
      ST_STOP: begin
        nxt_state = ST_STOP;
      end
      ST_SUSPEND: begin
        if (susp_wake) begin
          nxt_state = ST_RUN;
        end
      end
    endcase
    // Any reset overrides every state and returns the core to run.
    if (any_reset) begin
      nxt_state = ST_RUN;
    end
  end

  // ==========================================================================
  // State classification
  function automatic logic cpu_halted(input pwr_state_t s);
    cpu_halted = (s == ST_IDLE) || (s == ST_STOP) || (s == ST_SUSPEND);
  endfunction

  function automatic logic osc_stopped(input pwr_state_t s);
    osc_stopped = (s == ST_STOP) || (s == ST_SUSPEND);
  endfunction

  wire halted       = cpu_halted(nxt_state);
  wire osc_off      = osc_stopped(nxt_state);
  // A reset is not a wake: resume_pulse stays low when a reset ends idle or
  // suspend, because the core restarts from the reset vector instead.
  wire waking       = ((state_ff == ST_IDLE) || (state_ff == ST_SUSPEND)) && (nxt_state == ST_RUN) && !any_reset;
  wire susp_clear   = waking && (state_ff == ST_SUSPEND);
  // A wake clears the suspend bit; if the core writes the oscillator byte in
  // that same cycle, the hardware clear wins.
  wire [REG_W-1:0] osc_nxt = susp_clear ? (osc_ctrl_ff & ~(8'h01 << OSC_SUSPEND_BIT))
                                        : (osc_wr ? osc_wdata : osc_ctrl_ff);
  // The mode-select bits are never stored, so they always read back as zero.
  wire [REG_W-1:0] gp_nxt  = pwr_wr ? {pwr_wdata[REG_W-1:2], 2'b00} : gp_flags_ff;

  // ==========================================================================
  // Synchronisers
  // Three stages per pin. The first may go metastable, so nothing but the
  // second stage reads it. A level only moves once stages two and three
  // agree, which costs four to five cycles from pin to decision; the
  // external reset and the suspend wake sources all see this latency.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_sync_ff  <= 3'h0;
      port_sync_ff <= 3'h0;
      cmp_sync_ff  <= 3'h0;
      t3_sync_ff   <= 3'h0;
    end else begin
      ext_sync_ff  <= {ext_sync_ff[1:0], ext_reset};
      port_sync_ff <= {port_sync_ff[1:0], port_match};
      cmp_sync_ff  <= {cmp_sync_ff[1:0], comparator_low};
      t3_sync_ff   <= {t3_sync_ff[1:0], timer3_overflow};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_level_ff  <= 1'b0;
      port_level_ff <= 1'b0;
      cmp_level_ff  <= 1'b0;
      t3_level_ff   <= 1'b0;
      t3_prev_ff    <= 1'b0;
    end else begin
      ext_level_ff  <= ext_level_nxt;
      port_level_ff <= port_level_nxt;
      cmp_level_ff  <= cmp_level_nxt;
      t3_level_ff   <= t3_level_nxt;
      t3_prev_ff    <= t3_level_ff;
    end
  end

  // ==========================================================================
  // State, control registers and outputs
  // Every reset source, not only rst_n, restarts the machine in run and
  // clears both control bytes. The reset itself is what ends stop; the
  // core learns to restart from the reset vector through vector_load.
  always_ff @(posedge clock) begin
    if (!rst_n || any_reset) begin
      state_ff    <= ST_RUN;
      gp_flags_ff <= GP_FLAGS_RST;
      osc_ctrl_ff <= GP_FLAGS_RST;
    end else begin
      state_ff    <= nxt_state;
      gp_flags_ff <= gp_nxt;
      osc_ctrl_ff <= osc_nxt;
    end
  end

  // Halting only gates clocks; no storage is cleared, so contents survive.
  // Idle gates only the CPU clock. Stop and suspend also stop the internal
  // oscillator and the timers; the missing clock detector and the wake pin
  // synchronisers sit outside that gating, so they keep watching.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cpu_clk_en_ff    <= 1'b1;
      periph_clk_en_ff <= 1'b1;
      int_osc_run_ff   <= 1'b1;
      timers_run_ff    <= 1'b1;
    end else begin
      cpu_clk_en_ff    <= !halted;
      periph_clk_en_ff <= !osc_off;
      int_osc_run_ff   <= !osc_off;
      timers_run_ff    <= !osc_off;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      int_reset_req_ff <= 1'b0;
      vector_load_ff   <= 1'b0;
      resume_pulse_ff  <= 1'b0;
      analog_enable_ff <= '0;
    end else begin
      // Only internal causes raise the request; the core sees its own pin.
      int_reset_req_ff <= wd_reset || mcd_reset;
      vector_load_ff   <= any_reset;
      // The core keeps its program counter, so it resumes after the setting
      // instruction and then takes the pending interrupt.
      resume_pulse_ff  <= waking;
      // Each analog block follows its own disable bit; there is no global
      // switch, so software powers down only what it does not need.
      analog_enable_ff <= ~analog_disable;
    end
  end

  // ==========================================================================
  // Outputs
  // Every output below is a flip-flop, apart from the fixed restart address.
  assign power_control_rd      = gp_flags_ff;
  assign oscillator_control_rd = osc_ctrl_ff;
  assign cpu_clk_en            = cpu_clk_en_ff;
  assign periph_clk_en         = periph_clk_en_ff;
  assign int_osc_run           = int_osc_run_ff;
  assign timers_run            = timers_run_ff;
  assign int_reset_req         = int_reset_req_ff;
  assign fetch_vector          = RESET_VECTOR;
  assign vector_load           = vector_load_ff;
  assign resume_pulse          = resume_pulse_ff;
  assign analog_enable         = analog_enable_ff;

endmodule // power_mode_controller

`default_nettype wire
